// ---- pkg/awc_consts.svh ----
`ifndef AWC_CONSTS_SVH
`define AWC_CONSTS_SVH

// ----------------------------------------
// Register offsets and control reset value
// ----------------------------------------
`define AWC_OFS_CTRL     12'h000
`define AWC_OFS_STATUS   12'h004
`define AWC_CTRL_RST     2'h0

// ----------------------------------------
// Field positions
// ----------------------------------------
`define AWC_CTRL_ROM     0
`define AWC_CTRL_RAM     1

// ----------------------------------------
// Status fields
// ----------------------------------------
`define AWC_ST_STATE_HI  1
`define AWC_ST_STATE_LO  0
`define AWC_ST_CNT_HI    6
`define AWC_ST_CNT_LO    4
`define AWC_ST_PWR       8
`define AWC_ST_RDY       9
`define AWC_ST_RST       10

// ----------------------------------------
// Wait-state counts
// ----------------------------------------
`define AWC_WS_INTA      3'h4
`define AWC_WS_IO8       3'h4
`define AWC_WS_IO16      3'h1
`define AWC_WS_OFF8      3'h4
`define AWC_WS_OFF16     3'h1
`define AWC_WS_ROM_FAST  3'h1
`define AWC_WS_ROM_SLOW  3'h2
`define AWC_WS_RAM_WR    3'h1
`define AWC_WS_RAM_SLOW  3'h1
`define AWC_WS_RAM_FAST  3'h0

// ----------------------------------------
// Synchroniser depth to reset output
// ----------------------------------------
`define AWC_SYNC_LAT     3

`endif

// ---- pkg/awc_pkg.sv ----
package awc_pkg;

   typedef enum logic [1:0] {
      awc_idle  = 2'b00,
      awc_count = 2'b01,
      awc_end   = 2'b10
   } awc_state_e;

   typedef logic [2:0] awc_cnt_t;

endpackage

// ---- logic/awc_sync.sv ----
`timescale 1ns/100ps

// ----------------------------------------
// Two-flop level synchroniser
// ----------------------------------------
module awc_sync #(
   parameter logic RST_VAL = 1'b0
) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic async_in,
   output      logic sync_out
);
   logic meta_ff;
   logic sync_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_ff <= RST_VAL;
         sync_ff <= RST_VAL;
      end else begin
         meta_ff <= async_in;
         sync_ff <= meta_ff;
      end
   end

   assign sync_out = sync_ff;
endmodule

// ---- logic/awc_wait_ctrl.sv ----
// Operation
// - A 16-bit I/O cycle without interrupt acknowledge gets exactly one wait state whatever the other decode inputs say.
// - An off-board 8-bit memory cycle gets four wait states.
// - An off-board 16-bit memory cycle gets one wait state.
// - An on-board ROM read gets one wait state with ROM wait select set and two with it clear.
// - Every on-board RAM write gets one wait state regardless of RAM wait select.
// - An on-board RAM read gets one wait state with RAM wait select set and none with it clear.
// - During data conversion buffer direction is low for writes and high for reads.
// - DMA address enable goes low whenever either DMA grant is active.
// - High-byte enable is low under grant two and follows inverted address bit 0 under grant one.
// - In bus master mode data direction is low only for I/O reads at low port range off coproc.
// - Power good is asynchronous and is synchronised before it makes the reset.
// - The ready line is only pulled low or released, never driven high.
// - Interrupt acknowledge and 8-bit I/O cycles each get four wait states.
// - Channel ready low holds the cycle and zero-wait low ends it at once.
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/100ps
`include "awc_consts.svh"

module awc_wait_ctrl #(
   parameter int CNT_W = 3
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output      logic [31:0] prdata,
   output      logic        pready,
   output      logic        pslverr,
   input  wire logic        cycle_start,
   input  wire logic        cycle_inta,
   input  wire logic        cycle_io,
   input  wire logic        cycle_write,
   input  wire logic        rom_select,
   input  wire logic        onboard_decode,
   input  wire logic        mem_wide_select_n,
   input  wire logic        io_wide_select_n,
   input  wire logic        chan_ready,
   input  wire logic        zero_wait_n,
   input  wire logic        ready_n_in,
   output      logic        ready_n_out,
   output      logic        ready_n_oe,
   input  wire logic        conv_active,
   output      logic        buffer_direction,
   output      logic        buffer_gate,
   input  wire logic        dma_grant_one_n,
   input  wire logic        dma_grant_two_n,
   input  wire logic        cpu_high_byte_n,
   input  wire logic        xbus_addr_bit0,
   output      logic        dma_addr_enable_n,
   output      logic        xbus_high_byte_enable_n,
   input  wire logic        master_n,
   input  wire logic        hold_ack,
   input  wire logic        io_read_n,
   input  wire logic        xbus_addr_bit9,
   input  wire logic        xbus_addr_bit8,
   input  wire logic        coproc_select_n,
   output      logic        xbus_data_direction,
   input  wire logic        power_ok,
   output      logic        system_reset
);
   import awc_pkg::*;

   // ----------------------------------------
   // Register bus
   // ----------------------------------------
   logic [1:0]       ctrl_ff;
   logic [31:0]      prdata_ff;
   logic             rom_wait_select;
   logic             ram_wait_select;
   logic             setup_ph;
   logic             access_ph;
   logic             hit_ctrl;
   logic             hit_status;
   logic [31:0]      nxt_prdata;
   awc_state_e       state_ff;
   awc_state_e       nxt_state;
   logic [CNT_W-1:0] cnt_ff;
   logic [CNT_W-1:0] nxt_cnt;
   logic [CNT_W-1:0] load_val;
   logic             power_ok_sync;
   logic             system_reset_ff;

   assign rom_wait_select = ctrl_ff[`AWC_CTRL_ROM];
   assign ram_wait_select = ctrl_ff[`AWC_CTRL_RAM];
   assign setup_ph        = psel && !penable;
   assign access_ph       = psel && penable;
   assign hit_ctrl        = (paddr == `AWC_OFS_CTRL);
   assign hit_status      = (paddr == `AWC_OFS_STATUS);
   assign pready          = 1'b1;
   assign pslverr         = access_ph && !hit_ctrl && !hit_status;
   assign prdata          = prdata_ff;

   always_comb begin
      nxt_prdata = 32'h0000_0000;
      if (hit_ctrl) begin
         nxt_prdata[`AWC_CTRL_RAM:`AWC_CTRL_ROM] = ctrl_ff;
      end else if (hit_status) begin
         nxt_prdata[`AWC_ST_STATE_HI:`AWC_ST_STATE_LO] = state_ff;
         nxt_prdata[`AWC_ST_CNT_HI:`AWC_ST_CNT_LO]     = 3'(cnt_ff);
         nxt_prdata[`AWC_ST_PWR]                       = power_ok_sync;
         nxt_prdata[`AWC_ST_RDY]                       = ready_n_in;
         nxt_prdata[`AWC_ST_RST]                       = system_reset_ff;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff <= `AWC_CTRL_RST;
      end else if (access_ph && pwrite && hit_ctrl) begin
         ctrl_ff <= pwdata[1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= 32'h0000_0000;
      end else if (setup_ph && !pwrite) begin
         prdata_ff <= nxt_prdata;
      end
   end

   // ----------------------------------------
   // Power good and reset
   // ----------------------------------------
   // synchronise power good
   awc_sync #(
      .RST_VAL (1'b0)
   ) u_pwr_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in (power_ok),
      .sync_out (power_ok_sync)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         system_reset_ff <= 1'b1;
      end else begin
         system_reset_ff <= !power_ok_sync;
      end
   end

   assign system_reset = system_reset_ff;

   // ----------------------------------------
   // Wait-state decode
   // ----------------------------------------
   always_comb begin
      load_val = CNT_W'(`AWC_WS_INTA);
      if (cycle_inta) begin
         load_val = CNT_W'(`AWC_WS_INTA);
      end else if (cycle_io) begin
         if (!io_wide_select_n) begin
            load_val = CNT_W'(`AWC_WS_IO16);
         end else begin
            load_val = CNT_W'(`AWC_WS_IO8);
         end
      end else if (!onboard_decode) begin
         if (mem_wide_select_n) begin
            load_val = CNT_W'(`AWC_WS_OFF8);
         end else begin
            load_val = CNT_W'(`AWC_WS_OFF16);
         end
      end else if (cycle_write) begin
         load_val = CNT_W'(`AWC_WS_RAM_WR);
      end else if (rom_select) begin
         load_val = rom_wait_select ? CNT_W'(`AWC_WS_ROM_FAST) : CNT_W'(`AWC_WS_ROM_SLOW);
      end else begin
         load_val = ram_wait_select ? CNT_W'(`AWC_WS_RAM_SLOW) : CNT_W'(`AWC_WS_RAM_FAST);
      end
   end

   // ----------------------------------------
   // Cycle state machine
   // ----------------------------------------
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      case (state_ff)
         awc_idle: begin
            if (cycle_start) begin
               nxt_state = awc_count;
               nxt_cnt   = load_val;
            end
         end
         awc_count: begin
            if (!zero_wait_n) begin
               nxt_state = awc_end;
            end else if (cnt_ff != '0) begin
               nxt_cnt = cnt_ff - CNT_W'(1);
            end else if (chan_ready) begin
               nxt_state = awc_end;
            end
         end
         awc_end: begin
            nxt_state = awc_idle;
         end
         default: begin
            nxt_state = awc_idle;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= awc_idle;
      end else if (system_reset_ff) begin
         state_ff <= awc_idle;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

   assign ready_n_out = 1'b0;
   assign ready_n_oe  = (state_ff == awc_end);

   // ----------------------------------------
   // Bus steering
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         buffer_direction <= 1'b1;
         buffer_gate      <= 1'b0;
      end else begin
         buffer_direction <= !(conv_active && cycle_write);
         buffer_gate      <= conv_active;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dma_addr_enable_n       <= 1'b1;
         xbus_high_byte_enable_n <= 1'b1;
      end else begin
         dma_addr_enable_n <= dma_grant_one_n && dma_grant_two_n;
         if (!dma_grant_two_n) begin
            xbus_high_byte_enable_n <= 1'b0;
         end else if (!dma_grant_one_n) begin
            xbus_high_byte_enable_n <= !xbus_addr_bit0;
         end else begin
            xbus_high_byte_enable_n <= cpu_high_byte_n;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xbus_data_direction <= 1'b1;
      end else begin
         xbus_data_direction <= !(hold_ack && !master_n && !io_read_n && !xbus_addr_bit9
                                  && !xbus_addr_bit8 && coproc_select_n);
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   logic start_ok;
   assign start_ok = cycle_start && (state_ff == awc_idle) && !system_reset_ff;

   a_io16_waits: assert property (
      @(posedge pclk) disable iff (!presetn)
      start_ok && !cycle_inta && cycle_io && !io_wide_select_n
      |=> cnt_ff == CNT_W'(`AWC_WS_IO16))
      else $error("wide I/O count wrong");

   a_off8_waits: assert property (
      @(posedge pclk) disable iff (!presetn)
      start_ok && !cycle_inta && !cycle_io && !onboard_decode && mem_wide_select_n
      |=> cnt_ff == CNT_W'(`AWC_WS_OFF8))
      else $error("off-board narrow count wrong");

   a_off16_waits: assert property (
      @(posedge pclk) disable iff (!presetn)
      start_ok && !cycle_inta && !cycle_io && !onboard_decode && !mem_wide_select_n
      |=> cnt_ff == CNT_W'(`AWC_WS_OFF16))
      else $error("off-board wide count wrong");

   a_rom_waits: assert property (
      @(posedge pclk) disable iff (!presetn)
      start_ok && !cycle_inta && !cycle_io && onboard_decode && !cycle_write && rom_select
      |=> cnt_ff == (rom_wait_select ? CNT_W'(`AWC_WS_ROM_FAST) : CNT_W'(`AWC_WS_ROM_SLOW)))
      else $error("ROM count wrong");

   a_ramwr_waits: assert property (
      @(posedge pclk) disable iff (!presetn)
      start_ok && !cycle_inta && !cycle_io && onboard_decode && cycle_write
      |=> cnt_ff == CNT_W'(`AWC_WS_RAM_WR))
      else $error("RAM write count wrong");

   a_ramrd_waits: assert property (
      @(posedge pclk) disable iff (!presetn)
      start_ok && !cycle_inta && !cycle_io && onboard_decode && !cycle_write && !rom_select
      |=> cnt_ff == (ram_wait_select ? CNT_W'(`AWC_WS_RAM_SLOW) : CNT_W'(`AWC_WS_RAM_FAST)))
      else $error("RAM read count wrong");

   a_conv_dir: assert property (
      @(posedge pclk) disable iff (!presetn)
      conv_active |=> buffer_direction == !$past(cycle_write))
      else $error("buffer direction wrong");

   a_dma_aen: assert property (
      @(posedge pclk) disable iff (!presetn)
      (!dma_grant_one_n || !dma_grant_two_n) |=> !dma_addr_enable_n)
      else $error("DMA address enable missing");

   a_dma_bhe: assert property (
      @(posedge pclk) disable iff (!presetn)
      dma_grant_two_n && !dma_grant_one_n |=> xbus_high_byte_enable_n == !$past(xbus_addr_bit0))
      else $error("high byte enable wrong");

   a_master_dir: assert property (
      @(posedge pclk) disable iff (!presetn)
      !xbus_data_direction |-> $past(!io_read_n && coproc_select_n && !xbus_addr_bit9))
      else $error("data direction low without cause");

   a_pwr_sync: assert property (
      @(posedge pclk) disable iff (!presetn)
      !power_ok ##1 !power_ok ##1 !power_ok |=> system_reset_ff)
      else $error("reset not from synced power good");

   a_ready_od: assert property (
      @(posedge pclk) disable iff (!presetn)
      ready_n_oe |-> !ready_n_out ##1 !ready_n_oe)
      else $error("ready driven high or held");

   a_inta_waits: assert property (
      @(posedge pclk) disable iff (!presetn)
      start_ok && (cycle_inta || (cycle_io && io_wide_select_n)) ##1 zero_wait_n
      |-> cnt_ff == CNT_W'(`AWC_WS_INTA) ##1 cnt_ff == CNT_W'(`AWC_WS_INTA) - CNT_W'(1))
      else $error("four-wait count wrong");

   a_chan_hold: assert property (
      @(posedge pclk) disable iff (!presetn)
      state_ff == awc_count && zero_wait_n && !chan_ready && !system_reset_ff
      |=> state_ff == awc_count)
      else $error("cycle not held");

   a_count_down: assert property (
      @(posedge pclk) disable iff (!presetn)
      state_ff == awc_count && zero_wait_n && cnt_ff != '0 && !system_reset_ff
      |=> cnt_ff == $past(cnt_ff) - CNT_W'(1))
      else $error("count not decremented");
endmodule

// ---- test/awc_far_end.sv ----
`timescale 1ns/100ps

// ----------------------------------------
// Far side: ready line and overrides
// ----------------------------------------
module awc_far_end (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       cycle_start,
   input  wire logic       ready_n_oe,
   input  wire logic       ready_n_out,
   input  wire logic [1:0] mode,
   output      logic       chan_ready,
   output      logic       zero_wait_n,
   output      logic       ready_n_in
);
   logic [3:0] stall_ff;
   logic       zw_ff;
   logic       pull_ff;
   logic       low_pull;

   // stall or early end, never both
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stall_ff <= 4'h0;
         zw_ff    <= 1'b1;
      end else begin
         zw_ff <= !(cycle_start && mode == 2'h2);
         if (cycle_start && mode == 2'h1) begin
            stall_ff <= 4'h9;
         end else if (stall_ff != 4'h0) begin
            stall_ff <= stall_ff - 4'h1;
         end
      end
   end
   assign chan_ready  = (stall_ff == 4'h0);
   assign zero_wait_n = zw_ff;

   assign low_pull = ready_n_oe && !ready_n_out;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pull_ff <= 1'b1;
      end else begin
         pull_ff <= !low_pull;
      end
   end
   assign ready_n_in = low_pull ? 1'b0 : pull_ff;
endmodule

// ---- test/awc_wait_ctrl_tb_top.sv ----
`timescale 1ns/100ps

module awc_wait_ctrl_tb_top;
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end

   typedef struct packed {
      logic [1:0] ctrl;
      logic [6:0] ty;
      logic [3:0] n;
   } awc_row_s;
   typedef struct packed {
      logic [11:0] in;
      logic [4:0]  out;
   } awc_stp_s;

   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        cycle_start, cycle_inta, cycle_io, cycle_write, rom_select;
   logic        onboard_decode, mem_wide_select_n, io_wide_select_n;
   logic        chan_ready, zero_wait_n, ready_n_in, ready_n_out, ready_n_oe;
   logic        conv_active, buffer_direction, buffer_gate;
   logic        dma_grant_one_n, dma_grant_two_n, cpu_high_byte_n, xbus_addr_bit0;
   logic        dma_addr_enable_n, xbus_high_byte_enable_n, master_n, hold_ack;
   logic        io_read_n, xbus_addr_bit9, xbus_addr_bit8, coproc_select_n;
   logic        xbus_data_direction, power_ok, system_reset;
   logic [1:0]  far_mode;
   int          error_cnt, compares, cyc, k;

   awc_row_s rows [13] = '{
      '{2'h0, 7'h44, 4'h4},  // interrupt acknowledge
      '{2'h0, 7'h25, 4'h4},  // 8-bit I/O
      '{2'h0, 7'h22, 4'h1},  // 16-bit I/O over off-board
      '{2'h0, 7'h2e, 4'h1},  // 16-bit I/O over ROM
      '{2'h0, 7'h03, 4'h4},  // off-board 8-bit read
      '{2'h0, 7'h13, 4'h4},  // off-board 8-bit write
      '{2'h0, 7'h01, 4'h1},  // off-board 16-bit
      '{2'h1, 7'h0f, 4'h1},  // ROM fast
      '{2'h2, 7'h0f, 4'h2},  // ROM slow
      '{2'h0, 7'h17, 4'h1},  // RAM write
      '{2'h3, 7'h17, 4'h1},  // RAM write
      '{2'h2, 7'h07, 4'h1},  // RAM read slow
      '{2'h1, 7'h07, 4'h0}   // RAM read fast
   };
   awc_stp_s steer [12] = '{
      '{12'hfa9, 5'h0f}, '{12'hba9, 5'h1f},  // conversion write, read
      '{12'h139, 5'h13}, '{12'h1f9, 5'h11},  // first grant
      '{12'h2b9, 5'h11}, '{12'h329, 5'h15},  // second grant, none
      '{12'h391, 5'h16}, '{12'h395, 5'h17},  // master I/O read
      '{12'h393, 5'h17}, '{12'h390, 5'h17},  // port range, coproc
      '{12'h399, 5'h17}, '{12'h381, 5'h17}   // no read, no hold
   };

   awc_wait_ctrl awc_wait_ctrl_i (.*);

   awc_far_end awc_far_end_i (
      .pclk        (pclk),
      .presetn     (presetn),
      .cycle_start (cycle_start),
      .ready_n_oe  (ready_n_oe),
      .ready_n_out (ready_n_out),
      .mode        (far_mode),
      .chan_ready  (chan_ready),
      .zero_wait_n (zero_wait_n),
      .ready_n_in  (ready_n_in)
   );

   // ----------------------------------------
   // Clock, timeout, bus tasks
   // ----------------------------------------
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      cyc++;
      if (cyc > 5000) begin
         error_cnt++;
         close_out();
      end
   end

   task automatic close_out();
      if (error_cnt == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      r = prdata;
      e = pslverr;
      {psel, penable} <= 2'h0;
   endtask

   task automatic run_cyc(input logic [6:0] ty, output int n);
      @(posedge pclk);
      {cycle_inta, cycle_io, cycle_write, rom_select, onboard_decode,
       mem_wide_select_n, io_wide_select_n} <= ty;
      cycle_start <= 1'b1;
      @(posedge pclk);
      cycle_start <= 1'b0;
      n = 0;
      do begin
         @(posedge pclk);
         #1;
         n++;
      end while (ready_n_oe !== 1'b1 && n < 30);
      `CHK({ready_n_out, ready_n_in}, {1'b0, n >= 30})
      @(posedge pclk);
      #1;
      `CHK(ready_n_oe, 1'b0)
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {psel, penable, pwrite, paddr, pwdata, cycle_start} = '0;
      {cycle_inta, cycle_io, cycle_write, rom_select, onboard_decode} = '0;
      {mem_wide_select_n, io_wide_select_n, conv_active} = 3'h6;
      {dma_grant_one_n, dma_grant_two_n, cpu_high_byte_n, xbus_addr_bit0} = 4'he;
      {master_n, hold_ack, io_read_n, xbus_addr_bit9, xbus_addr_bit8} = 5'h14;
      {coproc_select_n, power_ok, far_mode} = 4'hc;
      presetn = 1'b0;
      repeat (2) @(posedge pclk);
      #1;
      `CHK({prdata, ready_n_oe, buffer_direction, buffer_gate}, 35'h0_0000_0002)
      `CHK({dma_addr_enable_n, xbus_high_byte_enable_n, xbus_data_direction, system_reset},
           4'hf)
      @(posedge pclk);
      presetn <= 1'b1;
      repeat (5) @(posedge pclk);
      #1;
      `CHK(system_reset, 1'b0)
      for (int i = 0; i < 13; i++) begin
         apb(1'b1, 12'h000, {30'h0, rows[i].ctrl}, rd, err);
         run_cyc(rows[i].ty, k);
         `CHK(k, int'(rows[i].n) + 1)
      end
      far_mode = 2'h1;
      run_cyc(7'h44, k);
      `CHK(k inside {[9:12]}, 1'b1)
      far_mode = 2'h2;
      run_cyc(7'h44, k);
      `CHK(k inside {[1:2]}, 1'b1)
      far_mode = 2'h0;
      apb(1'b1, 12'h000, 32'hffff_ffff, rd, err);
      apb(1'b0, 12'h000, 32'h0, rd, err);
      `CHK({err, rd}, 33'h0_0000_0003)
      apb(1'b1, 12'h004, 32'h0, rd, err);
      apb(1'b0, 12'h004, 32'h0, rd, err);
      `CHK({err, rd[10:8], rd[1:0]}, 6'h0c)
      apb(1'b1, 12'h008, 32'h0, rd, err);
      `CHK(err, 1'b1)
      apb(1'b0, 12'h008, 32'h0, rd, err);
      `CHK({err, rd}, 33'h1_0000_0000)
      for (int i = 0; i < 12; i++) begin
         @(posedge pclk);
         {conv_active, cycle_write, dma_grant_one_n, dma_grant_two_n, cpu_high_byte_n,
          xbus_addr_bit0, master_n, hold_ack, io_read_n, xbus_addr_bit9, xbus_addr_bit8,
          coproc_select_n} <= steer[i].in;
         @(posedge pclk);
         @(posedge pclk);
         #1;
         `CHK({buffer_direction, buffer_gate, dma_addr_enable_n, xbus_high_byte_enable_n,
               xbus_data_direction}, steer[i].out)
      end
      @(posedge pclk);
      power_ok <= 1'b0;
      @(posedge pclk);
      #1;
      `CHK(system_reset, 1'b0)
      repeat (2) @(posedge pclk);
      #1;
      `CHK(system_reset, 1'b1)
      run_cyc(7'h07, k);
      `CHK(k, 30)
      @(posedge pclk);
      power_ok <= 1'b1;
      repeat (5) @(posedge pclk);
      #1;
      `CHK(system_reset, 1'b0)
      @(posedge pclk);
      presetn <= 1'b0;
      @(posedge pclk);
      #1;
      `CHK({prdata, ready_n_oe, system_reset}, 34'h0_0000_0001)
      @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      #1;
      `CHK(system_reset, 1'b1)
      @(posedge pclk);
      #1;
      `CHK(system_reset, 1'b0)
      run_cyc(7'h07, k);
      `CHK(k, 1)
      close_out();
   end
endmodule
